// >>> rtl/atm_pkg.sv
// Constants, field layouts and carrier types of the advanced timer slice.
// Assumes a single core clock and a word-wide AHB-Lite register port.
package atm_pkg;

  // Register byte offsets in the 16-bit register space
  localparam logic [15:0] ATM_OFF_CTRL1 = 16'h0000;
  localparam logic [15:0] ATM_OFF_CTRL2 = 16'h0004;
  localparam logic [15:0] ATM_OFF_SMC = 16'h0008;
  localparam logic [15:0] ATM_OFF_IEN = 16'h000C;
  localparam logic [15:0] ATM_OFF_STS = 16'h0010;
  localparam logic [15:0] ATM_OFF_EG = 16'h0014;
  localparam logic [15:0] ATM_OFF_CCM1 = 16'h0018;
  localparam logic [15:0] ATM_OFF_CCM2 = 16'h001C;
  localparam logic [15:0] ATM_OFF_CCEN = 16'h0020;
  localparam logic [15:0] ATM_OFF_CNT = 16'h0024;
  localparam logic [15:0] ATM_OFF_PSC = 16'h0028;
  localparam logic [15:0] ATM_OFF_ARR = 16'h002C;
  localparam logic [15:0] ATM_OFF_REP = 16'h0030;
  localparam logic [15:0] ATM_OFF_CC1 = 16'h0034;
  localparam logic [15:0] ATM_OFF_CC2 = 16'h0038;
  localparam logic [15:0] ATM_OFF_CC3 = 16'h003C;
  localparam logic [15:0] ATM_OFF_CC4 = 16'h0040;
  localparam logic [15:0] ATM_OFF_BDT = 16'h0044;
  localparam logic [15:0] ATM_OFF_DCTL = 16'h0048;
  localparam logic [15:0] ATM_OFF_DADR = 16'h004C;

  // Field positions
  localparam int ATM_C1_RUN = 0;
  localparam int ATM_C1_UPD_DIS = 1;
  localparam int ATM_C1_DIR = 4;
  localparam int ATM_SMC_TRG_SRC = 4;
  localparam int ATM_C2_MST_LSB = 4;
  localparam int ATM_STS_UPD = 0;
  localparam int ATM_STS_CC1 = 1;
  localparam int ATM_STS_TRG = 6;
  localparam int ATM_STS_BRK = 7;
  localparam int ATM_IEN_DMA_LSB = 8;
  localparam int ATM_BDT_MOE = 15;
  localparam int ATM_DT_W = 8;
  localparam logic [7:0] ATM_DMA_MASK = 8'h5F;

  // Pin input indexes
  localparam int ATM_PIN_ENC_A = 0;
  localparam int ATM_PIN_ENC_B = 1;
  localparam int ATM_PIN_EXT = 2;
  localparam int ATM_PIN_MST = 3;
  localparam int ATM_PIN_BRK = 4;
  localparam int ATM_NPINS = 5;

  typedef enum logic [2:0] {
    ATM_SM_OFF = 3'h0, ATM_SM_ENC_A = 3'h1, ATM_SM_ENC_B = 3'h2, ATM_SM_ENC_AB = 3'h3,
    ATM_SM_RESET = 3'h4, ATM_SM_GATED = 3'h5, ATM_SM_TRIGGER = 3'h6, ATM_SM_EXTCLK = 3'h7
  } atm_slave_mode_t;

  typedef enum logic [2:0] {
    ATM_OC_FROZEN = 3'h0, ATM_OC_ACTIVE = 3'h1, ATM_OC_INACTIVE = 3'h2, ATM_OC_TOGGLE = 3'h3,
    ATM_OC_FORCE_LOW = 3'h4, ATM_OC_FORCE_HIGH = 3'h5, ATM_OC_PWM1 = 3'h6, ATM_OC_PWM2 = 3'h7
  } atm_cmp_mode_t;

  typedef enum logic [2:0] {
    ATM_MS_EG_UPDATE = 3'h0, ATM_MS_ENABLE = 3'h1, ATM_MS_UPDATE = 3'h2
  } atm_master_sel_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } atm_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } atm_ahb_rsp_t;

  typedef struct packed {
    logic [2:0] outMain;
    logic [2:0] outComp;
    logic trgOut;
    logic irq;
    logic [7:0] dmaReq;
  } atm_out_t;

endpackage

// >>> rtl/atm_timer.sv
// Advanced timer slice: encoder, slave modes, compare reference, dead time,
// event flags, interrupt and DMA requests, AHB-Lite register port.
// Assumes pins arrive asynchronously and the bus runs on core_clk.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// (R1) Three complementary output pairs never active together, dead time between them.
// (R2) Dead-time length comes from the break and dead-time register.
// (R3) Output channel with compare mode 100/101 forces reference inactive/active.
// (R4) Forced channels still raise compare flags, interrupts and DMA requests.
// (R5) Encoder counts on input A, input B or both, per slave function field.
// (R6) Encoder inputs use channel 1/2 polarity bits and input filters.
// (R7) Encoder counter moves only on valid filtered, polarity-corrected edges.
// (R8) Direction bit is read-only in encoder mode, recomputed on each edge.
// (R9) A edges count by level of B, B edges by level of A.
// (R10) Slave codes: 100 reset, 101 gated, 110 trigger.
// (R11) Reset mode: trigger rise clears counter (loads ARR when counting down) and prescaler, makes an update.
// (R12) Gated mode counts only while trigger is high; low holds the count.
// (R13) Trigger mode: trigger rise starts the counter without reset, never stops.
// (R14) Master output lets another timer reset, start, stop or clock this one.
// (R15) Interrupt from update, trigger, compare and break events.
// (R16) Selected events issue DMA requests, each with its own enable bit.
// (R17) Reference-clear enable with external trigger high holds reference low to update.
// (R18) Twenty registers at word offsets 0x00 to 0x4C in 16-bit space.
// (R19) Trigger mode sets run enable by hardware; other modes need software.
// (R20) Dead time delays each active-going output edge by the programmed count.
// (R21) Reference-clear enable low makes the external trigger ignored.
module atm_timer
  import atm_pkg::*;
#(
  parameter int DT_W = ATM_DT_W
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register bus
  input wire atm_pkg::atm_ahb_req_t ahbIn,
  output atm_pkg::atm_ahb_rsp_t ahbOut,
  // Pins: encoder A, encoder B, external trigger, master trigger, break
  input wire logic [atm_pkg::ATM_NPINS-1:0] pinIn,
  // Outputs, trigger, interrupt and DMA
  output atm_pkg::atm_out_t timerOut
);
  import atm_pkg::*;

  typedef struct packed {
    logic [15:0] ctrl1, ctrl2, smc, ien, sts, ccm1, ccm2, ccen, cnt, psc, arr, rep, bdt;
    logic [15:0] dctl, dadr, pscShadow, pscCnt;
    logic [3:0][15:0] cc;
    logic [ATM_NPINS-1:0][2:0] sync;
    logic [ATM_NPINS-1:0] pinLvl;
    logic [1:0][3:0] filtCnt;
    logic [1:0] filtLvl, encLvl;
    logic trgLvl;
    logic [3:0] cref, clrHold;
    logic [2:0][DT_W-1:0] dtCnt;
    logic [2:0] actMain, actComp;
    logic [15:0] addr;
    logic pendWrite, pendRead;
    atm_ahb_rsp_t rsp;
    atm_out_t out;
  } atm_state_t;

  localparam atm_state_t ATM_STATE_RST = '{
    rsp: '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0},
    default: '0
  };

  atm_state_t q;
  atm_state_t next_q;
  atm_slave_mode_t mode;
  atm_cmp_mode_t cmode;
  logic accept, wrEn, trgRise, isEnc, encStep, encDown, tick, ovf, updEvt, trgEvt;
  logic down;
  logic [15:0] wd, egBits;
  logic [7:0] setBits, cb;
  logic [3:0] match;
  logic [3:0] filt;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel mode byte: select [1:0], mode [6:4], clear [7], filter [7:4]
  function automatic logic [7:0] chanByte(input logic [15:0] m1, input logic [15:0] m2,
                                          input int c);
    logic [15:0] m;
    m = (c < 2) ? m1 : m2;
    return (c % 2 == 1) ? m[15:8] : m[7:0];
  endfunction

  function automatic logic [15:0] readReg(input atm_state_t s, input logic [15:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a) // R18
      ATM_OFF_CTRL1: v = s.ctrl1;
      ATM_OFF_CTRL2: v = s.ctrl2;
      ATM_OFF_SMC: v = s.smc;
      ATM_OFF_IEN: v = s.ien;
      ATM_OFF_STS: v = s.sts;
      ATM_OFF_CCM1: v = s.ccm1;
      ATM_OFF_CCM2: v = s.ccm2;
      ATM_OFF_CCEN: v = s.ccen;
      ATM_OFF_CNT: v = s.cnt;
      ATM_OFF_PSC: v = s.psc;
      ATM_OFF_ARR: v = s.arr;
      ATM_OFF_REP: v = s.rep;
      ATM_OFF_CC1: v = s.cc[0];
      ATM_OFF_CC2: v = s.cc[1];
      ATM_OFF_CC3: v = s.cc[2];
      ATM_OFF_CC4: v = s.cc[3];
      ATM_OFF_BDT: v = s.bdt;
      ATM_OFF_DCTL: v = s.dctl;
      ATM_OFF_DADR: v = s.dadr;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_q = q;
    mode = atm_slave_mode_t'(q.smc[2:0]); // R10
    cmode = ATM_OC_FROZEN;
    cb = 8'h00;
    filt = 4'h0;
    match = 4'h0;
    setBits = 8'h00;
    encStep = 1'b0;
    encDown = q.ctrl1[ATM_C1_DIR];
    tick = 1'b0;
    ovf = 1'b0;
    trgEvt = 1'b0;

    // Bus address phase; reads take one wait state so they see finished writes
    accept = ahbIn.hsel & ahbIn.htrans[1] & ahbIn.hready;
    wrEn = q.pendWrite;
    wd = ahbIn.hwdata[15:0];
    egBits = (wrEn && q.addr == ATM_OFF_EG) ? wd : 16'h0000;
    next_q.pendWrite = accept & ahbIn.hwrite;
    next_q.pendRead = accept & ~ahbIn.hwrite;
    if (accept)
    begin
      next_q.addr = ahbIn.haddr[15:0];
    end
    next_q.rsp.hreadyout = ~(accept & ~ahbIn.hwrite);
    next_q.rsp.hresp = 1'b0;
    if (q.pendRead)
    begin
      next_q.rsp.hrdata = {16'h0000, readReg(q, q.addr)};
    end

    // Three-stage pin synchronisers; a level counts once stages two and three agree
    for (int i = 0; i < ATM_NPINS; i++)
    begin
      next_q.sync[i] = {q.sync[i][1:0], pinIn[i]};
      if (q.sync[i][1] == q.sync[i][2])
      begin
        next_q.pinLvl[i] = q.sync[i][2];
      end
    end

    // Encoder input filters and polarity
    for (int i = 0; i < 2; i++)
    begin
      filt = 4'(chanByte(q.ccm1, q.ccm2, i) >> 4); // R6
      if (q.pinLvl[i] == q.filtLvl[i])
      begin
        next_q.filtCnt[i] = 4'h0;
      end
      else if (q.filtCnt[i] >= filt)
      begin
        next_q.filtLvl[i] = q.pinLvl[i];
        next_q.filtCnt[i] = 4'h0;
      end
      else
      begin
        next_q.filtCnt[i] = q.filtCnt[i] + 4'h1;
      end
      next_q.encLvl[i] = next_q.filtLvl[i] ^ q.ccen[4*i+1]; // R6
    end

    // Trigger input from the external trigger or another timer's master output
    next_q.trgLvl = q.smc[ATM_SMC_TRG_SRC] ? q.pinLvl[ATM_PIN_MST] : q.pinLvl[ATM_PIN_EXT];
    trgRise = next_q.trgLvl & ~q.trgLvl;

    // Encoder direction and count step
    isEnc = (mode == ATM_SM_ENC_A) || (mode == ATM_SM_ENC_B) || (mode == ATM_SM_ENC_AB);
    if ((mode == ATM_SM_ENC_A || mode == ATM_SM_ENC_AB) && next_q.encLvl[0] != q.encLvl[0])
    begin
      encStep = 1'b1; // R5 R7
      encDown = ~(next_q.encLvl[0] ^ q.encLvl[1]); // R9
    end
    else if ((mode == ATM_SM_ENC_B || mode == ATM_SM_ENC_AB)
             && next_q.encLvl[1] != q.encLvl[1])
    begin
      encStep = 1'b1; // R5 R7
      encDown = next_q.encLvl[1] ^ q.encLvl[0]; // R9
    end
    if (isEnc && encStep)
    begin
      next_q.ctrl1[ATM_C1_DIR] = encDown; // R8
    end
    down = next_q.ctrl1[ATM_C1_DIR];

    // Count source: prescaled clock, encoder edges or rises of the selected trigger input
    case (mode)
      ATM_SM_ENC_A, ATM_SM_ENC_B, ATM_SM_ENC_AB: tick = q.ctrl1[ATM_C1_RUN] & encStep; // R7
      ATM_SM_EXTCLK: tick = q.ctrl1[ATM_C1_RUN] & trgRise; // R14
      default:
      begin
        if (q.ctrl1[ATM_C1_RUN] && (mode != ATM_SM_GATED || q.trgLvl)) // R12 R19
        begin
          if (q.pscCnt == q.pscShadow)
          begin
            next_q.pscCnt = 16'h0000;
            tick = 1'b1;
          end
          else
          begin
            next_q.pscCnt = q.pscCnt + 16'h0001;
          end
        end
      end
    endcase
    if (tick && !down)
    begin
      ovf = (q.cnt == q.arr);
      next_q.cnt = ovf ? 16'h0000 : q.cnt + 16'h0001;
    end
    else if (tick)
    begin
      ovf = (q.cnt == 16'h0000);
      next_q.cnt = ovf ? q.arr : q.cnt - 16'h0001;
    end

    // Slave-mode trigger reactions
    case (mode)
      ATM_SM_RESET:
      begin
        trgEvt = trgRise;
        if (trgRise)
        begin
          next_q.cnt = down ? q.arr : 16'h0000; // R11
          next_q.pscCnt = 16'h0000; // R11
        end
      end
      ATM_SM_GATED: trgEvt = next_q.trgLvl ^ q.trgLvl;
      ATM_SM_TRIGGER, ATM_SM_EXTCLK: trgEvt = trgRise;
      default: trgEvt = 1'b0;
    endcase
    updEvt = (ovf & ~q.ctrl1[ATM_C1_UPD_DIS]) | egBits[ATM_STS_UPD]
             | (mode == ATM_SM_RESET && trgRise); // R11
    if (updEvt)
    begin
      next_q.pscShadow = q.psc;
      next_q.pscCnt = 16'h0000;
    end

    // Software writes; the counter write wins over counting
    if (wrEn)
    begin
      case (q.addr) // R18
        ATM_OFF_CTRL1:
        begin
          next_q.ctrl1 = wd;
          if (isEnc)
          begin
            next_q.ctrl1[ATM_C1_DIR] = down; // R8
          end
        end
        ATM_OFF_CTRL2: next_q.ctrl2 = wd;
        ATM_OFF_SMC: next_q.smc = wd;
        ATM_OFF_IEN: next_q.ien = wd;
        ATM_OFF_STS: next_q.sts = q.sts & wd;
        ATM_OFF_CCM1: next_q.ccm1 = wd;
        ATM_OFF_CCM2: next_q.ccm2 = wd;
        ATM_OFF_CCEN: next_q.ccen = wd;
        ATM_OFF_CNT: next_q.cnt = wd;
        ATM_OFF_PSC: next_q.psc = wd;
        ATM_OFF_ARR: next_q.arr = wd;
        ATM_OFF_REP: next_q.rep = wd;
        ATM_OFF_CC1: next_q.cc[0] = wd;
        ATM_OFF_CC2: next_q.cc[1] = wd;
        ATM_OFF_CC3: next_q.cc[2] = wd;
        ATM_OFF_CC4: next_q.cc[3] = wd;
        ATM_OFF_BDT: next_q.bdt = wd;
        ATM_OFF_DCTL: next_q.dctl = wd;
        ATM_OFF_DADR: next_q.dadr = wd;
        default: next_q.ctrl2 = q.ctrl2;
      endcase
    end
    if (mode == ATM_SM_TRIGGER && trgRise)
    begin
      next_q.ctrl1[ATM_C1_RUN] = 1'b1; // R13 R19
    end

    // Compare references, external clear, compare flags
    for (int c = 0; c < 4; c++)
    begin
      cb = chanByte(q.ccm1, q.ccm2, c);
      cmode = atm_cmp_mode_t'(cb[6:4]);
      match[c] = (next_q.cnt == q.cc[c]) && (next_q.cnt != q.cnt);
      if (updEvt)
      begin
        next_q.clrHold[c] = 1'b0; // R17
      end
      if (cb[7] && q.pinLvl[ATM_PIN_EXT])
      begin
        next_q.clrHold[c] = 1'b1; // R17
      end
      if (cb[1:0] == 2'b00)
      begin
        case (cmode)
          ATM_OC_ACTIVE: next_q.cref[c] = q.cref[c] | match[c];
          ATM_OC_INACTIVE: next_q.cref[c] = q.cref[c] & ~match[c];
          ATM_OC_TOGGLE: next_q.cref[c] = q.cref[c] ^ match[c];
          ATM_OC_FORCE_LOW: next_q.cref[c] = 1'b0; // R3
          ATM_OC_FORCE_HIGH: next_q.cref[c] = 1'b1; // R3
          ATM_OC_PWM1: next_q.cref[c] = next_q.cnt < q.cc[c];
          ATM_OC_PWM2: next_q.cref[c] = !(next_q.cnt < q.cc[c]);
          default: next_q.cref[c] = q.cref[c];
        endcase
        if (cb[7] && next_q.clrHold[c]) // R21
        begin
          next_q.cref[c] = 1'b0; // R17
        end
        setBits[ATM_STS_CC1+c] = match[c]; // R4
      end
    end

    // Dead time on the three complementary pairs
    for (int c = 0; c < 3; c++)
    begin
      if (next_q.cref[c] != q.cref[c])
      begin
        next_q.dtCnt[c] = q.bdt[DT_W-1:0]; // R2 R20
      end
      else if (q.dtCnt[c] != '0)
      begin
        next_q.dtCnt[c] = q.dtCnt[c] - 1'b1; // R20
      end
      next_q.actMain[c] = next_q.cref[c] & (next_q.dtCnt[c] == '0); // R1
      next_q.actComp[c] = ~next_q.cref[c] & (next_q.dtCnt[c] == '0); // R1
      next_q.out.outMain[c] = q.bdt[ATM_BDT_MOE] & q.ccen[4*c]
                              & (next_q.actMain[c] ^ q.ccen[4*c+1]);
      next_q.out.outComp[c] = q.bdt[ATM_BDT_MOE] & q.ccen[4*c+2]
                              & (next_q.actComp[c] ^ q.ccen[4*c+3]);
    end

    // Event flags: hardware set wins over a software clear
    setBits[ATM_STS_UPD] = updEvt;
    setBits[ATM_STS_TRG] = trgEvt | egBits[ATM_STS_TRG];
    setBits[ATM_STS_BRK] = (next_q.pinLvl[ATM_PIN_BRK] & ~q.pinLvl[ATM_PIN_BRK])
                           | egBits[ATM_STS_BRK];
    for (int c = 0; c < 4; c++)
    begin
      setBits[ATM_STS_CC1+c] = setBits[ATM_STS_CC1+c] | egBits[ATM_STS_CC1+c];
    end
    next_q.sts[7:0] = next_q.sts[7:0] | setBits; // R15
    next_q.out.irq = |(next_q.sts[7:0] & q.ien[7:0]); // R15
    next_q.out.dmaReq = setBits & ATM_DMA_MASK & q.ien[ATM_IEN_DMA_LSB +: 8]; // R16

    // Master trigger output toward a slave timer
    case (atm_master_sel_t'(q.ctrl2[ATM_C2_MST_LSB +: 3])) // R14
      ATM_MS_EG_UPDATE: next_q.out.trgOut = egBits[ATM_STS_UPD];
      ATM_MS_ENABLE: next_q.out.trgOut = next_q.ctrl1[ATM_C1_RUN];
      ATM_MS_UPDATE: next_q.out.trgOut = updEvt;
      default: next_q.out.trgOut = next_q.cref[0];
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= ATM_STATE_RST;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign ahbOut = q.rsp;
  assign timerOut = q.out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_chk @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  pair_exclusive_a: assert property (!(|(q.actMain & q.actComp))) // R1
    else $error("main and complementary active together");
  dt_load_a: assert property ((q.cref[0] != $past(q.cref[0])) // R2
    |-> q.dtCnt[0] == $past(q.bdt[DT_W-1:0]))
    else $error("dead-time count not loaded from register");
  dt_delay_a: assert property ($rose(q.cref[0]) && q.dtCnt[0] != '0 // R20
    |-> !q.actMain[0] ##1 !q.actMain[0] || q.dtCnt[0] == '0)
    else $error("main output rose before dead time ran out");
  force_low_a: assert property (q.ccm1[1:0] == 2'b00 && q.ccm1[6:4] == 3'h4 // R3
    |=> !q.cref[0])
    else $error("forced-inactive reference not low");
  force_flag_a: assert property (q.ccm1[1:0] == 2'b00 && q.ccm1[6:4] == 3'h5 // R4
    && q.cnt != $past(q.cnt) && q.cnt == $past(q.cc[0]) |-> q.sts[ATM_STS_CC1])
    else $error("forced channel lost its compare flag");
  enc_dir_a: assert property (q.smc[2:0] == 3'h3 && $rose(q.encLvl[0]) // R9
    && $past(q.encLvl[1]) && !$past(q.pendWrite) |-> q.ctrl1[ATM_C1_DIR])
    else $error("encoder direction wrong on input A rise");
  enc_count_a: assert property ($past(q.smc[2:0]) == 3'h3 && $past(q.ctrl1[ATM_C1_RUN]) // R7
    && $stable(q.encLvl) && !$past(q.pendWrite) |-> $stable(q.cnt))
    else $error("encoder counter moved without an edge");
  reset_mode_a: assert property ($past(q.smc[2:0]) == 3'h4 && $rose(q.trgLvl) // R11
    && !$past(q.pendWrite) && !q.ctrl1[ATM_C1_DIR] |-> q.cnt == 16'h0000 && q.sts[0])
    else $error("reset mode did not clear counter");
  gated_hold_a: assert property (q.smc[2:0] == 3'h5 && !q.trgLvl && !q.pendWrite // R12
    |=> $stable(q.cnt))
    else $error("gated counter moved with trigger low");
  trig_start_a: assert property ($past(q.smc[2:0]) == 3'h6 && $rose(q.trgLvl) // R13
    |-> q.ctrl1[ATM_C1_RUN])
    else $error("trigger mode did not start counter");
  ref_clear_a: assert property (q.ccm1[7] && q.ccm1[1:0] == 2'b00 // R17
    && q.pinLvl[ATM_PIN_EXT] |=> !q.cref[0])
    else $error("reference not cleared by external trigger");

endmodule // atm_timer

// >>> sim/atm_partner.sv
// Encoder, trigger, master and break sources on the far side of the pins.
// Assumes the bench calls move just after a rising core_clk edge.
`timescale 1ns/1ps
module atm_partner
  import atm_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Pin levels toward the timer
  output logic [atm_pkg::ATM_NPINS-1:0] pinLvl
);
  initial pinLvl = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // One level change, held long enough to pass the three-flop synchroniser
  task automatic move(input int pin, input logic lvl);
    @(posedge core_clk);
    pinLvl[pin] <= lvl;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // atm_partner

// >>> sim/atm_timer_test.sv
// Self-checking bench: registers, encoder, slave modes, outputs, events.
// Assumes atm_pkg, atm_timer and atm_partner are compiled first.
`timescale 1ns/1ps
module atm_timer_test;
  import atm_pkg::*;
  logic core_clk;
  logic reset_n;
  atm_ahb_req_t ahbIn;
  atm_ahb_req_t busIn;
  atm_ahb_rsp_t ahbOut;
  logic [ATM_NPINS-1:0] pinLvl;
  atm_out_t timerOut;
  int err_total;
  int num_checks;
  int seed;
  int dmaSeen;
  int mem [20];
  int seq [6] = '{0, 1, 0, 1, 1, 0};
  int cnt;
  int dt;
  int n;
  int m;
  logic dirm;
  logic [15:0] q;
  logic [15:0] q2;
  atm_timer #(.DT_W(ATM_DT_W)) atm_timer_inst
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .ahbIn(busIn),
    .ahbOut(ahbOut),
    .pinIn(pinLvl),
    .timerOut(timerOut)
  );
  atm_partner atm_partner_inst
  (
    .core_clk(core_clk),
    .pinLvl(pinLvl)
  );
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;
  // The single slave's ready is the bus ready
  always_comb
  begin
    busIn = ahbIn;
    busIn.hready = ahbOut.hreadyout;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Never both outputs of a pair active; count DMA pulses of channel 1
  // Sampled mid-cycle so a one-cycle pulse is seen exactly once
  always @(negedge core_clk)
  begin
    if (reset_n === 1'b1)
      chk({13'h0, timerOut.outMain & timerOut.outComp}, 16'h0000);
    if (timerOut.dmaReq[1] === 1'b1)
      dmaSeen++;
  end
  // Ready is taken before the edge, where it stands, never in the edge's own step
  task automatic waitRdy();
    int k;
    logic rdy;
    k = 0;
    do
    begin
      @(negedge core_clk);
      rdy = ahbOut.hreadyout;
      @(posedge core_clk);
      k++;
    end
    while (rdy !== 1'b1 && k < 100);
    if (rdy !== 1'b1)
      err_total++;
  endtask
  // Single word transfer; upper half of write data is random and ignored
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    ahbIn.haddr <= {16'h0000, a};
    ahbIn.htrans <= 2'h2;
    ahbIn.hwrite <= w;
    waitRdy();
    ahbIn.htrans <= 2'h0;
    ahbIn.hwdata <= {16'($random(seed)), d};
    waitRdy();
    r = ahbOut.hrdata[15:0];
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] r;
    bus(1'b0, a, 16'h0000, r);
    chk(r, e);
  endtask
  // Model: A edge steps down when levels agree, B edge steps up
  task automatic encStep(input int pin, input int pol);
    int ea;
    int eb;
    int d;
    atm_partner_inst.move(pin, ~pinLvl[pin]);
    ea = int'(pinLvl[0]) ^ pol;
    eb = int'(pinLvl[1]);
    if ((pin == 0 && m != 2) || (pin == 1 && m != 1))
    begin
      d = (ea == eb) ? ((pin == 0) ? -1 : 1) : ((pin == 0) ? 1 : -1);
      cnt += d;
      dirm = d < 0;
    end
    rd(ATM_OFF_CNT, cnt[15:0]);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 17;
    err_total = 0;
    num_checks = 0;
    dmaSeen = 0;
    reset_n = 1'b0;
    ahbIn.hsel = 1'b1;
    ahbIn.hsize = 3'h2;
    ahbIn.haddr = 32'h0;
    ahbIn.htrans = 2'h0;
    ahbIn.hwrite = 1'b0;
    ahbIn.hwdata = 32'h0;
    ahbIn.hready = 1'b1;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 20; i++)
      rd(16'(i * 4), 16'h0000);
    for (int i = 11; i < 20; i++)
    begin
      mem[i] = $random(seed) & 16'hFFFF;
      wr(16'(i * 4), 16'(mem[i]));
    end
    wr(16'h0050, 16'hFFFF);
    for (int i = 11; i < 20; i++)
      rd(16'(i * 4), 16'(mem[i]));
    rd(16'h0050, 16'h0000);
    $display("registers done");
    // Encoder: A only, B only, both, both with input A inverted
    wr(ATM_OFF_CCM1, 16'h0101);
    wr(ATM_OFF_ARR, 16'hFFFF);
    for (int k = 0; k < 4; k++)
    begin
      m = (k == 3) ? 3 : k + 1;
      wr(ATM_OFF_CTRL1, 16'h0000);
      wr(ATM_OFF_SMC, 16'(m));
      wr(ATM_OFF_CCEN, (k == 3) ? 16'h0002 : 16'h0000);
      wr(ATM_OFF_CNT, 16'h0100);
      wr(ATM_OFF_CTRL1, 16'h0001);
      cnt = 256;
      foreach (seq[i])
        encStep(seq[i], (k == 3) ? 1 : 0);
      wr(ATM_OFF_CTRL1, dirm ? 16'h0001 : 16'h0011);
      rd(ATM_OFF_CTRL1, dirm ? 16'h0011 : 16'h0001);
    end
    $display("encoder done");
    // Gated from the master trigger pin: count holds once the gate drops
    wr(ATM_OFF_CCM1, 16'h0000);
    wr(ATM_OFF_SMC, 16'h0015);
    wr(ATM_OFF_CTRL1, 16'h0001);
    wr(ATM_OFF_CNT, 16'h0000);
    atm_partner_inst.move(3, 1'b1);
    atm_partner_inst.move(3, 1'b0);
    bus(1'b0, ATM_OFF_CNT, 16'h0000, q);
    repeat (20) @(posedge core_clk);
    rd(ATM_OFF_CNT, q);
    chk({15'h0, q > 16'h0004 && q < 16'h0020}, 16'h0001);
    // Trigger mode: start without reset, no stop on the falling level
    wr(ATM_OFF_CTRL1, 16'h0000);
    wr(ATM_OFF_SMC, 16'h0006);
    wr(ATM_OFF_STS, 16'h0000);
    wr(ATM_OFF_CNT, 16'h0200);
    rd(ATM_OFF_CNT, 16'h0200);
    atm_partner_inst.move(2, 1'b1);
    rd(ATM_OFF_CTRL1, 16'h0001);
    atm_partner_inst.move(2, 1'b0);
    bus(1'b0, ATM_OFF_CNT, 16'h0000, q);
    bus(1'b0, ATM_OFF_CNT, 16'h0000, q2);
    chk({15'h0, q > 16'h0200 && q2 > q}, 16'h0001);
    bus(1'b0, ATM_OFF_STS, 16'h0000, q);
    chk({15'h0, q[ATM_STS_TRG]}, 16'h0001);
    // Reset mode: trigger rise clears the count and raises an update
    wr(ATM_OFF_SMC, 16'h0004);
    wr(ATM_OFF_STS, 16'h0000);
    wr(ATM_OFF_CNT, 16'h3000);
    atm_partner_inst.move(2, 1'b1);
    bus(1'b0, ATM_OFF_CNT, 16'h0000, q);
    chk({15'h0, q < 16'h0020}, 16'h0001);
    bus(1'b0, ATM_OFF_STS, 16'h0000, q);
    chk({15'h0, q[ATM_STS_UPD]}, 16'h0001);
    atm_partner_inst.move(2, 1'b0);
    // Clock from the master trigger pin: one rise, one count
    wr(ATM_OFF_SMC, 16'h0017);
    wr(ATM_OFF_CNT, 16'h0000);
    atm_partner_inst.move(3, 1'b1);
    atm_partner_inst.move(3, 1'b0);
    rd(ATM_OFF_CNT, 16'h0001);
    wr(ATM_OFF_CTRL2, 16'h0010);
    repeat (2) @(posedge core_clk);
    chk({15'h0, timerOut.trgOut}, 16'h0001);
    wr(ATM_OFF_STS, 16'h0000);
    wr(ATM_OFF_EG, 16'h0040);
    rd(ATM_OFF_STS, 16'h0040);
    $display("slave modes done");
    // Forced levels and dead time on channel 1
    wr(ATM_OFF_SMC, 16'h0000);
    dt = 4 + ($random(seed) & 15);
    wr(ATM_OFF_BDT, 16'h8000 | 16'(dt));
    wr(ATM_OFF_CCEN, 16'h0005);
    wr(ATM_OFF_CCM1, 16'h0040);
    repeat (30) @(posedge core_clk);
    chk({14'h0, timerOut.outMain[0], timerOut.outComp[0]}, 16'h0001);
    wr(ATM_OFF_CCM1, 16'h0050);
    n = 0;
    while (timerOut.outMain[0] !== 1'b1 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({15'h0, n >= dt - 1 && n <= dt + 3}, 16'h0001);
    $display("outputs done");
    // Compare event while forced; interrupt, DMA, mask, break
    wr(ATM_OFF_CC1, 16'h0005);
    wr(ATM_OFF_IEN, 16'h0282);
    wr(ATM_OFF_STS, 16'h0000);
    dmaSeen = 0;
    wr(ATM_OFF_CNT, 16'h0000);
    repeat (20) @(posedge core_clk);
    bus(1'b0, ATM_OFF_STS, 16'h0000, q);
    chk({15'h0, q[ATM_STS_CC1]}, 16'h0001);
    chk({15'h0, timerOut.irq}, 16'h0001);
    chk(16'(dmaSeen), 16'h0001);
    wr(ATM_OFF_IEN, 16'h0080);
    repeat (2) @(posedge core_clk);
    chk({15'h0, timerOut.irq}, 16'h0000);
    atm_partner_inst.move(4, 1'b1);
    chk({15'h0, timerOut.irq}, 16'h0001);
    // Reference clear from the external trigger, off then on
    wr(ATM_OFF_CC1, 16'hFFFF);
    wr(ATM_OFF_CNT, 16'h0000);
    wr(ATM_OFF_CCM1, 16'h0060);
    atm_partner_inst.move(2, 1'b1);
    repeat (30) @(posedge core_clk);
    chk({15'h0, timerOut.outMain[0]}, 16'h0001);
    wr(ATM_OFF_CCM1, 16'h00E0);
    repeat (10) @(posedge core_clk);
    chk({15'h0, timerOut.outMain[0]}, 16'h0000);
    atm_partner_inst.move(2, 1'b0);
    repeat (30) @(posedge core_clk);
    chk({15'h0, timerOut.outMain[0]}, 16'h0000);
    $display("events done");
    end_sim();
  end
endmodule // atm_timer_test
